// ===== inc/btag_pkg.sv
package btag_pkg;
   localparam int          BTAG_AW            = 16;
   localparam logic [15:0] BTAG_PC_RESET      = 16'h0000;
   localparam logic [15:0] BTAG_TABLE_BASE    = 16'h0040;
   localparam logic [15:0] BTAG_TABLE_LAST    = 16'h007F;
   localparam logic [15:0] BTAG_SP_RESET      = 16'hFF00;
   localparam logic [15:0] BTAG_HSRAM_LO      = 16'hFE20;
   localparam logic [15:0] BTAG_HSRAM_HI      = 16'hFEFF;
   localparam int          BTAG_IDX_LSB       = 1;
   localparam int          BTAG_IDX_MSB       = 5;
   localparam int          BTAG_DISP_SIGN_BIT = 7;

   typedef enum logic [2:0] {
      BTAG_OP_SEQ   = 3'h0,
      BTAG_OP_REL   = 3'h1,
      BTAG_OP_ABS   = 3'h2,
      BTAG_OP_TBL   = 3'h3,
      BTAG_OP_REG   = 3'h4,
      BTAG_OP_RET   = 3'h5
   } btag_op_e;

   typedef enum logic [2:0] {
      BTAG_ST_IDLE  = 3'b000,
      BTAG_ST_TLO   = 3'b001,
      BTAG_ST_THI   = 3'b011,
      BTAG_ST_PUSHL = 3'b010,
      BTAG_ST_PUSHH = 3'b110,
      BTAG_ST_POPL  = 3'b111,
      BTAG_ST_POPH  = 3'b101
   } btag_state_e;
endpackage : btag_pkg

// ===== hw/btag_rel_adder.sv
`timescale 1ns/100ps
// =====================================================
// relative target adder
module btag_rel_adder
   import btag_pkg::*;
(
   input  wire logic [15:0] next_pc,
   input  wire logic [7:0]  signed_branch_offset,
   output logic      [15:0] target
);
   logic [15:0] ext;
   // sign bit replicated into the upper byte
   assign ext    = {{8{signed_branch_offset[BTAG_DISP_SIGN_BIT]}}, signed_branch_offset};
   // carry out of bit 15 dropped by width
   assign target = 16'(next_pc + ext);
endmodule : btag_rel_adder

// ===== hw/btag_next_pc.sv
`timescale 1ns/100ps
// Behaviour
// - no branch: counter advances by instruction byte length, one per byte.
// - relative target is next instruction start plus 8-bit displacement.
// - displacement is two's complement, bit 7 sign, extended to 16 bits.
// - relative form used by short branch and every conditional branch.
// - absolute call and branch load 16-bit immediate into counter.
// - table call index is instruction bits 1 to 5.
// - table entries live at 40H..7FH; fetched target may be anywhere.
// - register-indirect branch loads counter from accumulator pair.
// - direct operand access uses the 16-bit immediate address.
// - calls and returns save/restore return address via stack pointer in RAM.
module btag_next_pc
   import btag_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        srst,
   input  wire logic        instr_valid,
   input  wire logic [2:0]  instr_len,
   input  wire logic [2:0]  branch_op,
   input  wire logic        is_call,
   input  wire logic        cond_branch,
   input  wire logic        cond_taken,
   input  wire logic [7:0]  signed_branch_offset,
   input  wire logic [15:0] absolute_target_field,
   input  wire logic [7:0]  opcode,
   input  wire logic [15:0] accumulator_pair,
   input  wire logic        direct_access,
   input  wire logic        sp_load,
   input  wire logic [15:0] sp_load_value,
   input  wire logic [7:0]  mem_rdata,
   output logic             busy,
   output logic [15:0]      program_counter,
   output logic [15:0]      stack_pointer,
   output logic             mem_req,
   output logic             mem_we,
   output logic [15:0]      mem_addr,
   output logic [7:0]       mem_wdata,
   output logic [15:0]      operand_addr,
   output logic             operand_valid
);
   btag_state_e st_q;
   logic [15:0] program_counter_q;
   logic [15:0] stack_pointer_q;
   logic [15:0] ret_q;
   logic [15:0] tgt_q;
   logic [7:0]  lo_q;
   logic [15:0] operand_addr_q;
   logic        operand_valid_q;
   logic [15:0] seq_pc;
   logic [15:0] rel_pc;
   logic [4:0]  tbl_idx;
   logic [15:0] tbl_addr;
   logic        idle_go;
   logic        rel_take;

   function automatic logic [15:0] inc16(input logic [15:0] a, input logic [15:0] b);
      inc16 = 16'(a + b);
   endfunction : inc16

   function automatic logic [15:0] dec16(input logic [15:0] a);
      dec16 = 16'(a - 16'h0001);
   endfunction : dec16

   assign busy     = (st_q != BTAG_ST_IDLE);
   assign idle_go  = instr_valid && !busy;
   assign seq_pc   = inc16(program_counter_q, {13'h0000, instr_len});
   assign tbl_idx  = opcode[BTAG_IDX_MSB:BTAG_IDX_LSB];
   assign tbl_addr = BTAG_TABLE_BASE | {10'h000, tbl_idx, 1'b0};
   // unconditional short branches arrive with cond_branch low
   assign rel_take = !cond_branch || cond_taken;

   btag_rel_adder u_rel (
      .next_pc              (seq_pc),
      .signed_branch_offset (signed_branch_offset),
      .target               (rel_pc)
   );

   // =====================================================
   // sequencer
   always_ff @(posedge core_clk) begin
      if (srst) begin
         st_q <= BTAG_ST_IDLE;
      end else begin
         unique case (st_q)
            BTAG_ST_IDLE: begin
               if (idle_go && branch_op == BTAG_OP_TBL) begin
                  st_q <= BTAG_ST_TLO;
               end else if (idle_go && is_call && branch_op == BTAG_OP_ABS) begin
                  st_q <= BTAG_ST_PUSHH;
               end else if (idle_go && branch_op == BTAG_OP_RET) begin
                  st_q <= BTAG_ST_POPL;
               end
            end
            BTAG_ST_TLO:   st_q <= BTAG_ST_THI;
            BTAG_ST_THI:   st_q <= BTAG_ST_PUSHH;
            BTAG_ST_PUSHH: st_q <= BTAG_ST_PUSHL;
            BTAG_ST_PUSHL: st_q <= BTAG_ST_IDLE;
            BTAG_ST_POPL:  st_q <= BTAG_ST_POPH;
            BTAG_ST_POPH:  st_q <= BTAG_ST_IDLE;
            default:       st_q <= BTAG_ST_IDLE;
         endcase
      end
   end

   // =====================================================
   // program counter
   always_ff @(posedge core_clk) begin
      if (srst) begin
         program_counter_q <= BTAG_PC_RESET;
         ret_q             <= 16'h0000;
         tgt_q             <= 16'h0000;
         lo_q              <= 8'h00;
      end else begin
         if (idle_go) begin
            ret_q <= seq_pc;
            unique case (branch_op)
               BTAG_OP_REL: program_counter_q <= rel_take ? rel_pc : seq_pc;
               BTAG_OP_ABS: begin
                  if (is_call) begin
                     tgt_q <= absolute_target_field;
                  end else begin
                     program_counter_q <= absolute_target_field;
                  end
               end
               BTAG_OP_TBL: ;
               BTAG_OP_REG: program_counter_q <= accumulator_pair;
               BTAG_OP_RET: ;
               default:     program_counter_q <= seq_pc;
            endcase
         end
         if (st_q == BTAG_ST_TLO) begin
            lo_q <= mem_rdata;
         end
         if (st_q == BTAG_ST_THI) begin
            tgt_q <= {mem_rdata, lo_q};
         end
         if (st_q == BTAG_ST_PUSHL) begin
            program_counter_q <= tgt_q;
         end
         if (st_q == BTAG_ST_POPL) begin
            lo_q <= mem_rdata;
         end
         if (st_q == BTAG_ST_POPH) begin
            program_counter_q <= {mem_rdata, lo_q};
         end
      end
   end

   // =====================================================
   // stack pointer; high byte pushed first so low ends at lower address
   always_ff @(posedge core_clk) begin
      if (srst) begin
         stack_pointer_q <= BTAG_SP_RESET;
      end else if (sp_load && !busy) begin
         stack_pointer_q <= sp_load_value;
      end else if (st_q == BTAG_ST_PUSHH || st_q == BTAG_ST_PUSHL) begin
         stack_pointer_q <= dec16(stack_pointer_q);
      end else if (st_q == BTAG_ST_POPL || st_q == BTAG_ST_POPH) begin
         stack_pointer_q <= inc16(stack_pointer_q, 16'h0001);
      end
   end

   // =====================================================
   // direct operand address
   always_ff @(posedge core_clk) begin
      if (srst) begin
         operand_addr_q  <= 16'h0000;
         operand_valid_q <= 1'b0;
      end else begin
         operand_valid_q <= idle_go && direct_access;
         if (idle_go && direct_access) begin
            operand_addr_q <= absolute_target_field;
         end
      end
   end

   // =====================================================
   // memory port, combinational request per state
   always_comb begin
      mem_req   = 1'b1;
      mem_we    = 1'b0;
      mem_addr  = 16'h0000;
      mem_wdata = 8'h00;
      unique case (st_q)
         BTAG_ST_TLO:   mem_addr = tbl_addr;
         BTAG_ST_THI:   mem_addr = inc16(tbl_addr, 16'h0001);
         BTAG_ST_PUSHH: begin
            mem_we    = 1'b1;
            mem_addr  = dec16(stack_pointer_q);
            mem_wdata = ret_q[15:8];
         end
         BTAG_ST_PUSHL: begin
            mem_we    = 1'b1;
            mem_addr  = dec16(stack_pointer_q);
            mem_wdata = ret_q[7:0];
         end
         BTAG_ST_POPL:  mem_addr = stack_pointer_q;
         BTAG_ST_POPH:  mem_addr = stack_pointer_q;
         default:       mem_req = 1'b0;
      endcase
   end

   assign program_counter = program_counter_q;
   assign stack_pointer   = stack_pointer_q;
   assign operand_addr    = operand_addr_q;
   assign operand_valid   = operand_valid_q;

   // =====================================================
   // checks
   AST_SEQ_ADV: assert property (@(posedge core_clk) disable iff (srst)
      idle_go && branch_op == BTAG_OP_SEQ |=> program_counter == $past(seq_pc))
      else $error("sequential advance wrong");
   AST_REL_TGT: assert property (@(posedge core_clk) disable iff (srst)
      idle_go && branch_op == BTAG_OP_REL && rel_take
      |=> program_counter == 16'($past(seq_pc) + {{8{$past(signed_branch_offset[7])}},
                                                  $past(signed_branch_offset)}))
      else $error("relative target wrong");
   AST_REL_SIGN: assert property (@(posedge core_clk) disable iff (srst)
      signed_branch_offset[7] |-> rel_pc != inc16(seq_pc, {8'h00, signed_branch_offset})
                               || signed_branch_offset == 8'h00)
      else $error("displacement not sign extended");
   AST_COND_NT: assert property (@(posedge core_clk) disable iff (srst)
      idle_go && branch_op == BTAG_OP_REL && cond_branch && !cond_taken
      |=> program_counter == $past(seq_pc))
      else $error("untaken branch moved");
   AST_ABS_BR: assert property (@(posedge core_clk) disable iff (srst)
      idle_go && branch_op == BTAG_OP_ABS && !is_call
      |=> program_counter == $past(absolute_target_field))
      else $error("absolute branch wrong");
   AST_TBL_ADDR: assert property (@(posedge core_clk) disable iff (srst)
      st_q == BTAG_ST_TLO |-> mem_addr == {9'h000, 1'b1, opcode[5:1], 1'b0})
      else $error("table index wrong");
   AST_TBL_RANGE: assert property (@(posedge core_clk) disable iff (srst)
      st_q == BTAG_ST_TLO || st_q == BTAG_ST_THI
      |-> mem_addr >= BTAG_TABLE_BASE && mem_addr <= BTAG_TABLE_LAST)
      else $error("table outside vector area");
   AST_TBL_LOAD: assert property (@(posedge core_clk) disable iff (srst)
      st_q == BTAG_ST_TLO ##1 st_q == BTAG_ST_THI ##1 1'b1 ##2 1'b1
      |-> program_counter == {$past(mem_rdata, 3), $past(mem_rdata, 4)})
      else $error("table entry byte order wrong");
   AST_REG_BR: assert property (@(posedge core_clk) disable iff (srst)
      idle_go && branch_op == BTAG_OP_REG |=> program_counter == $past(accumulator_pair))
      else $error("register branch wrong");
   AST_DIRECT: assert property (@(posedge core_clk) disable iff (srst)
      idle_go && direct_access |=> operand_valid && operand_addr == $past(absolute_target_field))
      else $error("direct address wrong");
   AST_PUSH: assert property (@(posedge core_clk) disable iff (srst)
      st_q == BTAG_ST_PUSHH |-> ##2 stack_pointer == 16'($past(stack_pointer, 2) - 16'h0002))
      else $error("push did not move stack pointer by two");
   AST_SP_LOAD: assert property (@(posedge core_clk) disable iff (srst)
      sp_load && !busy |=> stack_pointer == $past(sp_load_value))
      else $error("stack pointer load wrong");

   COV_REL_BACK: cover property (@(posedge core_clk)
      idle_go && branch_op == BTAG_OP_REL && signed_branch_offset[7] && rel_take);
   COV_TBL_CALL: cover property (@(posedge core_clk) st_q == BTAG_ST_THI);
   COV_RET:      cover property (@(posedge core_clk) st_q == BTAG_ST_POPH);
   COV_WRAP:     cover property (@(posedge core_clk) idle_go && rel_pc < seq_pc
                                 && !signed_branch_offset[7]);
endmodule : btag_next_pc

// ===== testbench/btag_prog_mem.sv
`timescale 1ns/100ps
// =====================================
// program memory and stack ram model
module btag_prog_mem
   import btag_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        mem_req,
   input  wire logic        mem_we,
   input  wire logic [15:0] mem_addr,
   input  wire logic [7:0]  mem_wdata,
   output logic      [7:0]  mem_rdata
);
   logic [7:0] mem [0:65535];
   logic [7:0] last_q = 8'hA5;
   // idle bus toggles so a stale byte never looks valid
   always_comb begin
      if (mem_req && !mem_we) begin
         mem_rdata = mem[mem_addr];
      end else begin
         mem_rdata = ~last_q;
      end
   end
   always @(posedge core_clk) begin
      if (mem_req && mem_we) begin
         mem[mem_addr] <= mem_wdata;
      end
      last_q <= mem_rdata;
   end
endmodule : btag_prog_mem

// ===== testbench/test_branch_target_address_gen.sv
`timescale 1ns/100ps
// =====================================
// next-address testbench
module test_branch_target_address_gen
   import btag_pkg::*;
   ;
   logic        core_clk, srst, instr_valid, is_call, cond_branch, cond_taken, busy;
   logic        direct_access, sp_load, mem_req, mem_we, operand_valid, ov_seen;
   logic [2:0]  instr_len, branch_op;
   logic [7:0]  signed_branch_offset, opcode, mem_rdata, mem_wdata;
   logic [15:0] absolute_target_field, accumulator_pair, sp_load_value, program_counter;
   logic [15:0] stack_pointer, mem_addr, operand_addr, exp_pc, exp_sp, ret;
   int          fails, total_checks;

   btag_next_pc uut (.core_clk(core_clk), .srst(srst), .instr_valid(instr_valid),
      .instr_len(instr_len), .branch_op(branch_op), .is_call(is_call), .opcode(opcode),
      .cond_branch(cond_branch), .cond_taken(cond_taken), .direct_access(direct_access),
      .signed_branch_offset(signed_branch_offset), .accumulator_pair(accumulator_pair),
      .absolute_target_field(absolute_target_field), .sp_load(sp_load), .busy(busy),
      .sp_load_value(sp_load_value), .mem_rdata(mem_rdata), .mem_req(mem_req),
      .program_counter(program_counter), .stack_pointer(stack_pointer), .mem_we(mem_we),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .operand_addr(operand_addr),
      .operand_valid(operand_valid));
   btag_prog_mem prog (.core_clk(core_clk), .mem_req(mem_req), .mem_we(mem_we),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : conclude

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // =====================================
   // one instruction, then wait for the sequencer to go idle
   task automatic issue(input logic [2:0] op, input logic [2:0] len, input logic call,
      input logic cb, input logic ct, input logic [7:0] off, input logic [15:0] tgt);
      int n;
      @(posedge core_clk);
      #1;
      instr_valid = 1'b1;
      {branch_op, instr_len, is_call, cond_branch, cond_taken} = {op, len, call, cb, ct};
      {signed_branch_offset, absolute_target_field} = {off, tgt};
      @(posedge core_clk);
      #1;
      {instr_valid, direct_access} = 2'b00;
      ov_seen = operand_valid;
      n = 0;
      while (busy !== 1'b0) begin
         if (n == 20) begin
            fails++;
            conclude();
         end
         @(posedge core_clk);
         #1;
         n++;
      end
      @(posedge core_clk);
      #1;
   endtask : issue

   // call (absolute or table), then return to the pushed address
   task automatic call_ret(input logic [2:0] op, input logic [2:0] len,
      input logic [15:0] tgt, input logic [15:0] dest);
      ret = exp_pc + 16'(len);
      issue(op, len, 1'(op == BTAG_OP_ABS), 1'b0, 1'b0, 8'h00, tgt);
      exp_sp = exp_sp - 16'h0002;
      check("call pc", program_counter, dest);
      check("call sp", stack_pointer, exp_sp);
      check("push hi", {8'h00, prog.mem[exp_sp + 16'h0001]}, {8'h00, ret[15:8]});
      check("push lo", {8'h00, prog.mem[exp_sp]}, {8'h00, ret[7:0]});
      issue(BTAG_OP_RET, 3'h1, 1'b0, 1'b0, 1'b0, 8'h00, 16'h0000);
      exp_sp = exp_sp + 16'h0002;
      exp_pc = ret;
      check("ret pc", program_counter, exp_pc);
      check("ret sp", stack_pointer, exp_sp);
   endtask : call_ret

   task automatic run_seq();
      for (int l = 1; l < 8; l++) begin
         issue(BTAG_OP_SEQ, 3'(l), 1'b0, 1'b0, 1'b0, 8'h00, 16'h0000);
         exp_pc = exp_pc + 16'(l);
         check("seq pc", program_counter, exp_pc);
      end
   endtask : run_seq

   // starts near the top so the first forward branch wraps
   task automatic run_rel();
      logic [7:0] offs [4] = '{8'h7F, 8'h80, 8'h05, 8'hF0};
      logic [1:0] cbt  [4] = '{2'b00, 2'b00, 2'b10, 2'b11};
      issue(BTAG_OP_ABS, 3'h3, 1'b0, 1'b0, 1'b0, 8'h00, 16'hFFF0);
      exp_pc = 16'hFFF0;
      check("abs pc", program_counter, exp_pc);
      for (int i = 0; i < 4; i++) begin
         issue(BTAG_OP_REL, 3'h2, 1'b0, cbt[i][1], cbt[i][0], offs[i], 16'h0000);
         exp_pc = exp_pc + 16'h0002;
         if (!cbt[i][1] || cbt[i][0]) exp_pc = exp_pc + {{8{offs[i][7]}}, offs[i]};
         check("rel pc", program_counter, exp_pc);
      end
   endtask : run_rel

   task automatic run_misc();
      accumulator_pair = 16'hBEEF;
      issue(BTAG_OP_REG, 3'h1, 1'b0, 1'b0, 1'b0, 8'h00, 16'h0000);
      exp_pc = 16'hBEEF;
      check("reg pc", program_counter, exp_pc);
      direct_access = 1'b1;
      issue(BTAG_OP_SEQ, 3'h3, 1'b0, 1'b0, 1'b0, 8'h00, 16'hFE00);
      exp_pc = exp_pc + 16'h0003;
      check("operand valid", 16'(ov_seen), 16'h0001);
      check("operand addr", operand_addr, 16'hFE00);
      check("direct pc", program_counter, exp_pc);
      check("operand pulse end", 16'(operand_valid), 16'h0000);
   endtask : run_misc

   // move the stack into the middle of the high-speed ram before the calls
   task automatic run_spload();
      @(posedge core_clk);
      #1;
      {sp_load, sp_load_value} = {1'b1, 16'hFE80};
      @(posedge core_clk);
      #1;
      sp_load = 1'b0;
      exp_sp = 16'hFE80;
      check("sp load", stack_pointer, exp_sp);
   endtask : run_spload

   task automatic run_table();
      prog.mem[16'h0040] = 8'h17;
      prog.mem[16'h0041] = 8'h3E;
      prog.mem[16'h007E] = 8'h5C;
      prog.mem[16'h007F] = 8'h9A;
      call_ret(BTAG_OP_ABS, 3'h3, 16'h4000, 16'h4000);
      // outer opcode bits set to prove only bits 5..1 index
      opcode = 8'hC1;
      call_ret(BTAG_OP_TBL, 3'h1, 16'h0000, 16'h3E17);
      opcode = 8'h3E;
      call_ret(BTAG_OP_TBL, 3'h1, 16'h0000, 16'h9A5C);
   endtask : run_table

   initial begin
      srst = 1'b1;
      {instr_valid, is_call, cond_branch, cond_taken, direct_access, sp_load} = '0;
      {instr_len, branch_op, signed_branch_offset, opcode} = '0;
      {absolute_target_field, accumulator_pair, sp_load_value} = '0;
      {fails, total_checks} = '0;
      exp_pc = BTAG_PC_RESET;
      exp_sp = BTAG_SP_RESET;
      repeat (4) @(posedge core_clk);
      #1;
      srst = 1'b0;
      check("reset pc", program_counter, exp_pc);
      check("reset sp", stack_pointer, exp_sp);
      run_seq();
      run_rel();
      run_misc();
      run_spload();
      run_table();
      conclude();
   end
endmodule : test_branch_target_address_gen
